// >>> include/sbcsec_pkg.sv
// constants, field layouts and types of the spi slave port with frame checking
// assumes a 16-bit frame, lsb first, address in the low byte, data in the high byte
package sbcsec_pkg;
    // --------------------------------------------------------------
    // frame layout
    // --------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam int ADDR_HI = 6;
    localparam int ADDR_LO = 0;
    localparam int RW_BIT = 7;
    localparam int DATA_HI = 15;
    localparam int DATA_LO = 8;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hffff;
    // --------------------------------------------------------------
    // register addresses
    // --------------------------------------------------------------
    localparam logic [6:0] CTRL_LAST = 7'h1e;
    localparam logic [6:0] STATUS_BASE = 7'h40;
    localparam logic [6:0] DEV_STAT_ADDR = 7'h43;
    localparam logic [6:0] MODE_CTRL_ADDR = 7'h01;
    localparam logic [6:0] WATCHDOG_CONTROL_REG_ADDR = 7'h02;
    localparam logic [6:0] MEAS_CTRL_ADDR = 7'h04;
    localparam logic [6:0] TIMER_CTRL_ADDR = 7'h0c;
    localparam logic [6:0] GPIO_CTRL_ADDR = 7'h17;
    // --------------------------------------------------------------
    // data fields
    // --------------------------------------------------------------
    localparam int MC_HI = 7;
    localparam int MC_LO = 6;
    localparam int MC_REST_HI = 5;
    localparam logic [1:0] MC_NORMAL = 2'h0;
    localparam logic [1:0] MC_SLEEP = 2'h1;
    localparam logic [1:0] MC_STOP = 2'h2;
    localparam logic [1:0] MC_SOFT_RESET = 2'h3;
    localparam logic WD_PARITY_EXPECT = 1'h1;
    localparam int MEAS_BIT = 2;
    localparam int TMR_ON_HI = 6;
    localparam int TMR_ON_LO = 4;
    localparam int TMR_PER_HI = 2;
    localparam int TMR_PER_LO = 0;
    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } sbcsec_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FRAME,
        ST_CHECK
    } sbcsec_state_t;
endpackage

// >>> rtl/sbcsec_sync.sv
// two-flop level synchroniser into the system clock
// assumes each bit is an independent level; no multi-bit coherence
`timescale 1ns/1ps
module sbcsec_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta_reg <= RST_VAL;
            q_out <= RST_VAL;
        end
        else if (ce_in)
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule

// >>> rtl/sbcsec_link.sv
// link side of the spi slave, clocked only by the master's shift clock
// assumes err_in and readback_in are steady while chip select is low
`timescale 1ns/1ps
module sbcsec_link (
    input wire logic sclk_in,
    input wire logic resetn_in,
    input wire logic chip_select_low_in,
    input wire logic sdi_in,
    input wire logic spi_enable_in,
    input wire logic reset_out_low_in,
    input wire logic err_in,
    input wire logic [14:0] readback_in,
    output logic [15:0] rx_word_out,
    output logic [4:0] rx_count_out,
    output logic frame_toggle_out,
    output logic sdo_out,
    output logic sdo_oe_out
);
    logic frame_rst_n;
    logic started_reg;
    logic [4:0] tx_idx_reg;
    logic [15:0] tx_word;

    // chip select high ends the frame; no shift clock arrives then
    assign frame_rst_n = resetn_in & ~chip_select_low_in;
    assign tx_word = {readback_in, err_in};

    // --------------------------------------------------------------
    // receive on falling edges
    // --------------------------------------------------------------
    always_ff @(negedge sclk_in or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            started_reg <= 1'b0;
        else
            started_reg <= 1'b1;
    end

    always_ff @(negedge sclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rx_word_out <= sbcsec_pkg::WORD_ZERO;
        else
            rx_word_out <= {sdi_in, rx_word_out[15:1]};
    end

    // word and count stay still after the frame, read quasi-statically
    always_ff @(negedge sclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rx_count_out <= sbcsec_pkg::CNT_ZERO;
            frame_toggle_out <= 1'b0;
        end
        else if (!started_reg)
        begin
            rx_count_out <= sbcsec_pkg::CNT_ONE;
            frame_toggle_out <= ~frame_toggle_out;
        end
        else if (rx_count_out != sbcsec_pkg::CNT_MAX)
            rx_count_out <= rx_count_out + sbcsec_pkg::CNT_ONE;
    end

    // --------------------------------------------------------------
    // transmit after rising edges
    // --------------------------------------------------------------
    always_ff @(posedge sclk_in or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            tx_idx_reg <= sbcsec_pkg::CNT_ZERO;
        else if (tx_idx_reg != sbcsec_pkg::CNT_MAX)
            tx_idx_reg <= tx_idx_reg + sbcsec_pkg::CNT_ONE;
    end

    // sdi is never routed to sdo: no pass-through for a chain
    always_comb
    begin
        if (!reset_out_low_in)
            sdo_out = 1'b1;
        else if (tx_idx_reg < sbcsec_pkg::CNT_FULL)
            sdo_out = tx_word[tx_idx_reg[3:0]];
        else
            sdo_out = 1'b0;
    end

    // released whenever chip select is high so others share the line
    assign sdo_oe_out = ~chip_select_low_in & (spi_enable_in | ~reset_out_low_in);
endmodule

// >>> rtl/sbcsec_top.sv
// spi slave port of the basis chip: framing, error flag and command checks
// assumes mode and configuration inputs come from logic on mclk_in
`timescale 1ns/1ps
// Function
// - spi only in init, normal, stop
// - full-duplex 16-bit frames, shared bus
// - frame opens on chip select low
// - chip select rise: interpret, release sdo
// - sample sdi on falling clock edges
// - next sdo bit after rising edges
// - no daisy chain pass-through
// - wrong command ignored, sticky error flag
// - stop to sleep: error, go restart
// - init to stop or sleep: error, normal
// - watchdog byte bad parity: error, ignore
// - stop mode accepts only listed commands
// - stop with pending wake: interrupt, no error
// - stop to normal with changes: mode only
// - sleep without wake source: error, restart
// - sleep with dead timer: wake to restart
// - measurement versus fail/gpio conflicts rejected
// - timer on-time not below period rejected
// - all-zero or all-one frame rejected
// - clock count not 0/16: error bit
// - frame during reset low: error, sdo high
// - address low bits, rw bit 7, data high
// - restart mode ignores spi traffic
module sbcsec_top (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic sclk_in,
    input wire logic chip_select_low_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire sbcsec_pkg::sbcsec_mode_t mode_in,
    input wire logic [5:0] mode_ctrl_cur_in,
    input wire logic wake_src_any_in,
    input wire logic timer_only_off_in,
    input wire logic wake_pending_in,
    input wire logic fail_output_active_in,
    input wire logic gpio_config_active_in,
    input wire logic voltage_measure_enable_in,
    input wire logic reset_out_low_in,
    input wire logic [14:0] readback_in,
    output logic wr_strobe_out,
    output logic rd_strobe_out,
    output logic rd_clear_out,
    output logic [6:0] cmd_addr_out,
    output logic [7:0] cmd_data_out,
    output logic mode_req_valid_out,
    output sbcsec_pkg::sbcsec_mode_t mode_req_out,
    output logic int_trigger_out,
    output logic cmd_error_out,
    output logic frame_error_out
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic is_spi_mode(input sbcsec_pkg::sbcsec_mode_t m);
        is_spi_mode = (m == sbcsec_pkg::MODE_INIT) || (m == sbcsec_pkg::MODE_NORMAL)
            || (m == sbcsec_pkg::MODE_STOP);
    endfunction
    // --------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------
    sbcsec_pkg::sbcsec_state_t state_reg, state_next;
    logic [15:0] rx_word;
    logic [4:0] rx_count;
    logic link_toggle, cs_low_s, sclk_s, tog_s;
    logic tog_seen_reg, edge_err_reg, rst_ovl_reg, err_flag_reg, cmd_err_reg, spi_en_reg;
    logic clocked, count_bad, frame_bad, interpret;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    logic cmd_rw, cmd_status;
    logic [1:0] mc_code;
    logic chk_err, chk_write, chk_read, chk_clear, chk_mreq_valid, chk_int;
    sbcsec_pkg::sbcsec_mode_t chk_mreq;

    // --------------------------------------------------------------
    // link domain and crossings
    // --------------------------------------------------------------
    sbcsec_link u_link (
        .sclk_in(sclk_in),
        .resetn_in(resetn_in),
        .chip_select_low_in(chip_select_low_in),
        .sdi_in(sdi_in),
        .spi_enable_in(spi_en_reg),
        .reset_out_low_in(reset_out_low_in),
        .err_in(err_flag_reg),
        .readback_in(readback_in),
        .rx_word_out(rx_word),
        .rx_count_out(rx_count),
        .frame_toggle_out(link_toggle),
        .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out)
    );
    // word and count are read unsynchronised: they only move inside a frame
    // select resets to its idle high level, else a false frame follows reset
    sbcsec_sync #(.WIDTH(3), .RST_VAL(3'h1)) u_sync (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .ce_in(ce_in),
        .d_in({link_toggle, sclk_in, chip_select_low_in}),
        .q_out({tog_s, sclk_s, cs_low_s})
    );

    // --------------------------------------------------------------
    // frame sequencing
    // --------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            sbcsec_pkg::ST_IDLE:
                if (!cs_low_s)
                    state_next = sbcsec_pkg::ST_FRAME;
            sbcsec_pkg::ST_FRAME:
                if (cs_low_s)
                    state_next = sbcsec_pkg::ST_CHECK;
            sbcsec_pkg::ST_CHECK:
                state_next = sbcsec_pkg::ST_IDLE;
            default:
                state_next = sbcsec_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state_reg <= sbcsec_pkg::ST_IDLE;
        else if (ce_in)
            state_reg <= state_next;
    end
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            spi_en_reg <= 1'b0;
        else if (ce_in)
            spi_en_reg <= is_spi_mode(mode_in);
    end

    // --------------------------------------------------------------
    // frame error detection
    // --------------------------------------------------------------
    // a changed toggle means the link saw at least one clock this frame
    assign clocked = (tog_s != tog_seen_reg);
    assign count_bad = clocked && (rx_count != sbcsec_pkg::CNT_FULL);
    assign frame_bad = count_bad | edge_err_reg | rst_ovl_reg;
    assign interpret = (state_reg == sbcsec_pkg::ST_CHECK) && clocked && !frame_bad
        && spi_en_reg;
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            tog_seen_reg <= 1'b0;
        else if (ce_in && state_reg == sbcsec_pkg::ST_CHECK)
            tog_seen_reg <= tog_s;
    end

    // clock level is checked on both chip select edges, same sync delay
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            edge_err_reg <= 1'b0;
        else if (ce_in)
        begin
            if (state_reg == sbcsec_pkg::ST_IDLE && !cs_low_s)
                edge_err_reg <= sclk_s;
            else if (state_reg == sbcsec_pkg::ST_FRAME && cs_low_s)
                edge_err_reg <= edge_err_reg | sclk_s;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rst_ovl_reg <= 1'b0;
        else if (ce_in)
        begin
            if (state_reg == sbcsec_pkg::ST_IDLE && !cs_low_s)
                rst_ovl_reg <= ~reset_out_low_in;
            else if (state_reg == sbcsec_pkg::ST_FRAME)
                rst_ovl_reg <= rst_ovl_reg | ~reset_out_low_in;
        end
    end

    // shown in the next frame, then replaced by that frame's verdict
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            err_flag_reg <= 1'b0;
        else if (ce_in && state_reg == sbcsec_pkg::ST_CHECK)
            err_flag_reg <= frame_bad;
    end

    // --------------------------------------------------------------
    // command decode and checks
    // --------------------------------------------------------------
    assign cmd_addr = rx_word[sbcsec_pkg::ADDR_HI:sbcsec_pkg::ADDR_LO];
    assign cmd_rw = rx_word[sbcsec_pkg::RW_BIT];
    assign cmd_data = rx_word[sbcsec_pkg::DATA_HI:sbcsec_pkg::DATA_LO];
    assign cmd_status = (cmd_addr >= sbcsec_pkg::STATUS_BASE);
    assign mc_code = cmd_data[sbcsec_pkg::MC_HI:sbcsec_pkg::MC_LO];

    always_comb
    begin
        chk_err = 1'b0;
        chk_write = 1'b0;
        chk_read = 1'b0;
        chk_clear = 1'b0;
        chk_mreq_valid = 1'b0;
        chk_mreq = sbcsec_pkg::MODE_NORMAL;
        chk_int = 1'b0;
        if (rx_word == sbcsec_pkg::WORD_ZERO || rx_word == sbcsec_pkg::WORD_ONES)
            chk_err = 1'b1;
        else if (cmd_status || !cmd_rw)
        begin
            chk_read = 1'b1;
            chk_clear = cmd_status && cmd_rw;
        end
        else if (cmd_addr == sbcsec_pkg::MODE_CTRL_ADDR)
        begin
            chk_mreq_valid = 1'b1;
            if (mode_in == sbcsec_pkg::MODE_INIT
                && (mc_code == sbcsec_pkg::MC_SLEEP || mc_code == sbcsec_pkg::MC_STOP))
            begin
                chk_err = 1'b1;
                chk_mreq = sbcsec_pkg::MODE_NORMAL;
            end
            else if (mode_in == sbcsec_pkg::MODE_STOP)
            begin
                case (mc_code)
                    sbcsec_pkg::MC_SLEEP:
                    begin
                        chk_err = 1'b1;
                        chk_mreq = sbcsec_pkg::MODE_RESTART;
                    end
                    sbcsec_pkg::MC_NORMAL:
                    begin
                        chk_mreq = sbcsec_pkg::MODE_NORMAL;
                        chk_err = (cmd_data[sbcsec_pkg::MC_REST_HI:0] != mode_ctrl_cur_in);
                    end
                    sbcsec_pkg::MC_SOFT_RESET:
                        chk_mreq = sbcsec_pkg::MODE_RESTART;
                    default:
                    begin
                        chk_mreq_valid = 1'b0;
                        chk_err = (cmd_data[sbcsec_pkg::MC_REST_HI:0] != mode_ctrl_cur_in);
                    end
                endcase
            end
            else
            begin
                case (mc_code)
                    sbcsec_pkg::MC_SLEEP:
                    begin
                        chk_write = 1'b1;
                        if (!wake_src_any_in)
                        begin
                            chk_err = 1'b1;
                            chk_mreq = sbcsec_pkg::MODE_RESTART;
                        end
                        else if (timer_only_off_in)
                            chk_mreq = sbcsec_pkg::MODE_RESTART;
                        else
                            chk_mreq = sbcsec_pkg::MODE_SLEEP;
                    end
                    sbcsec_pkg::MC_STOP:
                    begin
                        chk_write = 1'b1;
                        chk_mreq = sbcsec_pkg::MODE_STOP;
                        chk_int = wake_pending_in;
                    end
                    sbcsec_pkg::MC_SOFT_RESET:
                        chk_mreq = sbcsec_pkg::MODE_RESTART;
                    default:
                    begin
                        chk_write = 1'b1;
                        chk_mreq = sbcsec_pkg::MODE_NORMAL;
                    end
                endcase
            end
        end
        else if (cmd_addr == sbcsec_pkg::WATCHDOG_CONTROL_REG_ADDR)
        begin
            if ((^cmd_data) != sbcsec_pkg::WD_PARITY_EXPECT)
                chk_err = 1'b1;
            else
                chk_write = 1'b1;
        end
        else if (mode_in == sbcsec_pkg::MODE_STOP)
            chk_err = (cmd_addr <= sbcsec_pkg::CTRL_LAST);
        else if (cmd_addr == sbcsec_pkg::MEAS_CTRL_ADDR && cmd_data[sbcsec_pkg::MEAS_BIT]
            && (fail_output_active_in || gpio_config_active_in))
            chk_err = 1'b1;
        else if (cmd_addr == sbcsec_pkg::GPIO_CTRL_ADDR && voltage_measure_enable_in)
            chk_err = 1'b1;
        else if (cmd_addr == sbcsec_pkg::TIMER_CTRL_ADDR
            && cmd_data[sbcsec_pkg::TMR_ON_HI:sbcsec_pkg::TMR_ON_LO]
            >= cmd_data[sbcsec_pkg::TMR_PER_HI:sbcsec_pkg::TMR_PER_LO])
            chk_err = 1'b1;
        else if (cmd_addr <= sbcsec_pkg::CTRL_LAST)
            chk_write = 1'b1;
    end

    // --------------------------------------------------------------
    // sticky command error
    // --------------------------------------------------------------
    // a new error wins over a clear in the same command
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            cmd_err_reg <= 1'b0;
        else if (ce_in && interpret)
        begin
            if (chk_err)
                cmd_err_reg <= 1'b1;
            else if (chk_clear && cmd_addr == sbcsec_pkg::DEV_STAT_ADDR)
                cmd_err_reg <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // command outputs
    // --------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_strobe_out <= 1'b0;
            rd_strobe_out <= 1'b0;
            rd_clear_out <= 1'b0;
            mode_req_valid_out <= 1'b0;
            int_trigger_out <= 1'b0;
        end
        else if (ce_in)
        begin
            wr_strobe_out <= interpret && chk_write;
            rd_strobe_out <= interpret && chk_read;
            rd_clear_out <= interpret && chk_clear;
            mode_req_valid_out <= interpret && chk_mreq_valid;
            int_trigger_out <= interpret && chk_int;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cmd_addr_out <= sbcsec_pkg::WORD_ZERO[6:0];
            cmd_data_out <= sbcsec_pkg::WORD_ZERO[7:0];
            mode_req_out <= sbcsec_pkg::MODE_INIT;
        end
        else if (ce_in && interpret)
        begin
            cmd_addr_out <= cmd_addr;
            cmd_data_out <= cmd_data;
            mode_req_out <= chk_mreq;
        end
    end
    assign cmd_error_out = cmd_err_reg;
    assign frame_error_out = err_flag_reg;
endmodule

// >>> verif/sbcsec_assertions.sv
// pin and command-output checks for the spi slave port
// assumes binding to sbcsec_top; everything sampled on mclk_in
`timescale 1ns/1ps
module sbcsec_assertions (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic chip_select_low_in,
    input wire logic reset_out_low_in,
    input wire sbcsec_pkg::sbcsec_mode_t mode_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic wr_strobe_out,
    input wire logic rd_strobe_out,
    input wire logic rd_clear_out,
    input wire logic [6:0] cmd_addr_out,
    input wire logic mode_req_valid_out,
    input wire sbcsec_pkg::sbcsec_mode_t mode_req_out,
    input wire logic cmd_error_out
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_one_cycle; wr_strobe_out ##1 !wr_strobe_out; endsequence
    property p_oe_idle; chip_select_low_in |-> !sdo_oe_out; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo driven idle");
    property p_rst_high; !chip_select_low_in && !reset_out_low_in |-> sdo_oe_out && sdo_out;
    endproperty
    a_rst_high: assert property (p_rst_high) else $error("sdo not high");
    // one cycle of history so a mode change just before cs is not judged
    property p_off_mode; mode_in > sbcsec_pkg::MODE_STOP && reset_out_low_in
        && $past(mode_in) > sbcsec_pkg::MODE_STOP |-> !sdo_oe_out; endproperty
    a_off_mode: assert property (p_off_mode) else $error("spi active");
    property p_wr_pulse; wr_strobe_out |-> s_one_cycle; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("long strobe");
    property p_wr_late; wr_strobe_out |-> chip_select_low_in && $past(chip_select_low_in, 3);
    endproperty
    a_wr_late: assert property (p_wr_late) else $error("early strobe");
    property p_clear_kind; rd_clear_out |-> rd_strobe_out && cmd_addr_out[6]; endproperty
    a_clear_kind: assert property (p_clear_kind) else $error("bad clear");
    property p_err_fall; $fell(cmd_error_out) |->
        (rd_clear_out || $past(rd_clear_out)) && cmd_addr_out == 7'h43; endproperty
    a_err_fall: assert property (p_err_fall) else $error("flag lost");
    property p_init_req; mode_req_valid_out && mode_in == sbcsec_pkg::MODE_INIT |->
        mode_req_out != sbcsec_pkg::MODE_STOP && mode_req_out != sbcsec_pkg::MODE_SLEEP;
    endproperty
    a_init_req: assert property (p_init_req) else $error("init low power");
    property p_stop_sleep; mode_req_valid_out && mode_in == sbcsec_pkg::MODE_STOP |->
        mode_req_out != sbcsec_pkg::MODE_SLEEP; endproperty
    a_stop_sleep: assert property (p_stop_sleep) else $error("stop to sleep");
endmodule

// >>> verif/sbcsec_master.sv
// microcontroller model acting as spi master on the link clock
// assumes the bench resolves sdo to z while the slave releases it
`timescale 1ns/1ps
module sbcsec_master (
    output logic sclk_out,
    output logic cs_low_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    initial {sclk_out, cs_low_out, sdi_out} = 3'h2;
    // hi leaves the clock high across the select edge, a deliberate fault
    task automatic xfer(input logic [15:0] w, input int n, input bit hi, output logic [15:0] r);
        r = 16'h0;
        sclk_out = hi;
        #100 cs_low_out = 1'b0;
        #300 r[0] = sdo_in;
        // data moves on the rise so the slave's falling-edge sample is clean
        for (int i = 0; i < n; i++)
        begin
            #62.5 sclk_out = 1'b1;
            sdi_out = w[i];
            #62.5 sclk_out = 1'b0;
            if (i < 15) r[i + 1] = sdo_in;
        end
        #300 cs_low_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule

// >>> verif/test_sbc_spi_slave_error_check.sv
// self-checking bench: one table row per command case, then framing faults
// assumes sbcsec_master drives the link; readback is a fixed pattern
`timescale 1ns/1ps
module test_sbc_spi_slave_error_check;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic rol = 1'b1;
    logic [3:0] cond = 4'h4;
    logic [2:0] mode = 3'h1;
    logic sclk, csl, sdi, sdo, oe, wr, rd, rc, mv, it, cerr, fe;
    logic [6:0] ca;
    logic [7:0] cd;
    logic [2:0] mq, mreq;
    logic [15:0] r, wr_n, int_n, rd_n, error_cnt = 16'h0, n_compared = 16'h0;
    logic [31:0] t;
    // mode, {pend, src, toff, fail}, err, wr, mreq, int, wr free, word
    logic [31:0] tbl [20] = '{32'h28f05a85, 32'h29700000, 32'h2970ffff, 32'h09148081,
        32'h49444081, 32'h29700382, 32'h28f00182, 32'h49705a85, 32'h38ac8081, 32'h49140181,
        32'h21c04081, 32'h2cc04081, 32'h2b700484, 32'h2b700197, 32'h2970228c, 32'h68705a85,
        32'h88705a85, 32'ha8705a85, 32'h4844c081, 32'h48f00182};
    wire sdo_w = oe ? sdo : 1'bz;
    always #50 mclk_in = ~mclk_in;
    sbcsec_master u_m (.sclk_out(sclk), .cs_low_out(csl), .sdi_out(sdi), .sdo_in(sdo_w));
    sbcsec_top DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1), .sclk_in(sclk),
        .chip_select_low_in(csl), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe),
        .mode_in(sbcsec_pkg::sbcsec_mode_t'(mode)), .mode_ctrl_cur_in(6'h00),
        .wake_src_any_in(cond[2]), .timer_only_off_in(cond[1]), .wake_pending_in(cond[3]),
        .fail_output_active_in(cond[0]), .gpio_config_active_in(cond[0]),
        .voltage_measure_enable_in(cond[0]), .reset_out_low_in(rol), .readback_in(15'h1234),
        .wr_strobe_out(wr), .rd_strobe_out(rd), .rd_clear_out(rc), .cmd_addr_out(ca),
        .cmd_data_out(cd), .mode_req_valid_out(mv), .mode_req_out(mq),
        .int_trigger_out(it), .cmd_error_out(cerr), .frame_error_out(fe));
    always @(posedge mclk_in)
    begin
        if (wr === 1'b1) wr_n++;
        if (it === 1'b1) int_n++;
        if (rd === 1'b1 && rc === 1'b1) rd_n++;
        if (mv === 1'b1) mreq = mq;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // strobes land 4 +-1 edges after cs rises
    task automatic xf(input logic [15:0] w, input int n, input bit hi);
        u_m.xfer(w, n, hi, r);
        repeat (8) @(posedge mclk_in);
        #5;
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #1ms;
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        repeat (3) @(posedge mclk_in);
        #5 resetn_in = 1'b1;
        chk({fe, cerr}, 16'h0);
        repeat (4) @(posedge mclk_in);
        #5;
        foreach (tbl[i])
        begin
            t = tbl[i];
            {mode, cond} = t[31:25];
            {wr_n, int_n, mreq} = {32'h0, 3'h7};
            xf(t[15:0], 16, 1'b0);
            chk(cerr, t[24]);
            if (!t[18]) chk(wr_n, t[23]);
            chk(int_n, t[19]);
            if (t[22:20] != 3'h7) chk(mreq, t[22:20]);
            if (t[23]) chk({cd, 1'b0, ca}, {t[15:8], 1'b0, t[6:0]});
            if (mode < 3) chk(r, {15'h1234, 1'b0});
            mode = 3'h1;
            rd_n = 16'h0;
            xf(16'h00c3, 16, 1'b0);
            chk(cerr, 1'b0);
            chk(rd_n, 16'h1);
        end
        for (int i = 0; i < 3; i++)
        begin
            rol = (i != 2);
            wr_n = 16'h0;
            xf(16'h5a85, i ? 16 : 15, i == 1);
            rol = 1'b1;
            if (i == 2) chk(r, 16'hffff);
            chk(fe, 1'b1);
            chk(wr_n, 16'h0);
            xf(16'h0000, 0, 1'b0);
            chk(r[0], 1'b1);
        end
        end_of_test;
    end
endmodule
bind sbcsec_top sbcsec_assertions u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .chip_select_low_in(chip_select_low_in), .reset_out_low_in(reset_out_low_in),
    .mode_in(mode_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .wr_strobe_out(wr_strobe_out), .rd_strobe_out(rd_strobe_out), .rd_clear_out(rd_clear_out),
    .cmd_addr_out(cmd_addr_out), .mode_req_valid_out(mode_req_valid_out),
    .mode_req_out(mode_req_out), .cmd_error_out(cmd_error_out));
